// ### dms_map.svh
// Address map, field positions, reset values and widths for the data memory sector decoder.
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH

// ----------------------------------------------------------------------------
// Data memory layout
// ----------------------------------------------------------------------------
`define DMS_DATA_W         8
`define DMS_EXT_ADDR_W     9
`define DMS_SECTOR_BIT     8
`define DMS_SFR_LAST       8'h7F
`define DMS_GPR_FIRST      8'h80
`define DMS_GPR_DEPTH      128

// ----------------------------------------------------------------------------
// Special-function locations handled here
// ----------------------------------------------------------------------------
`define DMS_IND_ZERO       8'h00
`define DMS_PTR_ZERO       8'h01
`define DMS_IND_ONE        8'h02
`define DMS_OFS_ONE        8'h03
`define DMS_SEC_ONE        8'h04
`define DMS_IND_TWO        8'h0C
`define DMS_OFS_TWO        8'h0D
`define DMS_SEC_TWO        8'h0E
`define DMS_EE_CTRL        8'h40

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DMS_PTR_RESET      8'h00
`define DMS_EE_CTRL_RESET  8'h00

// ----------------------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------------------
`define DMS_APB_ADDR       12'h000
`define DMS_APB_WDATA      12'h004
`define DMS_APB_CTRL       12'h008
`define DMS_APB_RDATA      12'h00C
`define DMS_APB_PTRS       12'h010
`define DMS_APB_PROT       12'h014
`define DMS_CTRL_WR_BIT    0
`define DMS_CTRL_EXT_BIT   1
`define DMS_PROT_RESET     8'h00

`endif

// ### dms_pkg.sv
// Types shared by the data memory sector decoder.
package dms_pkg;

  typedef enum logic [2:0] {
    DMS_AREA_GPR,
    DMS_AREA_PTR,
    DMS_AREA_IND,
    DMS_AREA_EE,
    DMS_AREA_SFR,
    DMS_AREA_NONE
  } dms_area_e;

  typedef enum logic [1:0] {
    DMS_ST_IDLE,
    DMS_ST_ACCESS,
    DMS_ST_DONE
  } dms_state_e;

endpackage

// ### dms_gpr_ram.sv
// General-purpose RAM array of sector zero.
`timescale 1ns/10ps
`include "dms_map.svh"

module dms_gpr_ram #(
  parameter int DEPTH  = `DMS_GPR_DEPTH,
  parameter int DATA_W = `DMS_DATA_W
) (
  input  wire logic                     pclk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [DATA_W-1:0]        wdata,
  output logic      [DATA_W-1:0]        rdata
);

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // Left without reset so it maps to plain RAM, as volatile memory would be.
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ### dms_sector_decoder.sv
// Data memory sector decoder with pointers, indirect ports and APB access.
`timescale 1ns/10ps
`include "dms_map.svh"

// Operation
// - Data memory is volatile RAM with eight-bit locations.
// - Exactly two sectors, zero and one, each eight bits wide.
// - Offsets 00H to 7FH decode as special-function area.
// - Offsets 80H to FFH decode as readable and writable RAM in sector zero only.
// - Special registers mirror in both sectors; EEPROM control at 40H only sector one.
// - Protected special registers ignore program writes.
// - No bank-select register; sector comes from pointers or extended addresses.
// - Indirect sector comes from high pointer of pair one or two.
// - Indirect offset comes from low pointer of pair one or two.
// - Extended addresses have nine bits: sector bit plus eight-bit offset.
// - Extended direct access reaches every sector.
// - Unimplemented special locations read zero.
// - Indirect port access is redirected to the location its pointer names.
// - Port zero with its byte pointer reaches sector zero only.
// - Indirect port used as itself reads zero, writes do nothing.
module dms_sector_decoder (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  sfr_addr,
  output logic      [7:0]  sfr_wdata,
  output logic             sfr_wr,
  output logic             sfr_rd,
  input  wire logic [7:0]  sfr_rdata,
  input  wire logic        sfr_present
);

  // ----------------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------------
  function automatic dms_pkg::dms_area_e area_of(input logic sec, input logic [7:0] ofs);
    dms_pkg::dms_area_e a;
    a = dms_pkg::DMS_AREA_SFR;
    if (ofs >= `DMS_GPR_FIRST) begin
      a = sec ? dms_pkg::DMS_AREA_NONE : dms_pkg::DMS_AREA_GPR;
    end else if (ofs == `DMS_IND_ZERO || ofs == `DMS_IND_ONE || ofs == `DMS_IND_TWO) begin
      a = dms_pkg::DMS_AREA_IND;
    end else if (ofs == `DMS_PTR_ZERO || ofs == `DMS_OFS_ONE || ofs == `DMS_SEC_ONE ||
                 ofs == `DMS_OFS_TWO || ofs == `DMS_SEC_TWO) begin
      a = dms_pkg::DMS_AREA_PTR;
    end else if (ofs == `DMS_EE_CTRL) begin
      a = sec ? dms_pkg::DMS_AREA_EE : dms_pkg::DMS_AREA_NONE;
    end
    return a;
  endfunction

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [8:0]  cmd_addr;
  logic [7:0]  cmd_wdata;
  logic [7:0]  read_data;
  logic [7:0]  protect_mask;
  logic        cmd_wr;
  logic        cmd_ext;
  logic [7:0]  sector_zero_pointer;
  logic [7:0]  offset_pointer_one;
  logic [7:0]  sector_pointer_one;
  logic [7:0]  offset_pointer_two;
  logic [7:0]  sector_pointer_two;
  logic [7:0]  eeprom_control_reg;
  dms_pkg::dms_state_e state;
  logic        gpr_rd_pend;

  // ----------------------------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------------------------
  // Standard instructions only see sector zero; extended ones carry the sector bit.
  wire logic       direct_sec = cmd_ext & cmd_addr[`DMS_SECTOR_BIT];
  wire logic [7:0] direct_ofs = cmd_addr[7:0];
  wire logic       hit_ind0   = direct_ofs == `DMS_IND_ZERO;
  wire logic       hit_ind1   = direct_ofs == `DMS_IND_ONE;
  wire logic       hit_ind2   = direct_ofs == `DMS_IND_TWO;
  wire logic       via_ind    = hit_ind0 | hit_ind1 | hit_ind2;
  wire logic       ind_sec    = hit_ind1 ? sector_pointer_one[0] :
                                hit_ind2 ? sector_pointer_two[0] : 1'b0;
  wire logic [7:0] ind_ofs    = hit_ind1 ? offset_pointer_one :
                                hit_ind2 ? offset_pointer_two : sector_zero_pointer;
  wire logic       eff_sec    = via_ind ? ind_sec : direct_sec;
  wire logic [7:0] eff_ofs    = via_ind ? ind_ofs : direct_ofs;
  wire dms_pkg::dms_area_e eff_area = area_of(eff_sec, eff_ofs);
  wire logic [2:0] prot_idx   = eff_ofs[2:0];
  wire logic       is_prot    = eff_ofs[7:3] == 5'h01 && protect_mask[prot_idx];

  // ----------------------------------------------------------------------------
  // Execution strobes
  // ----------------------------------------------------------------------------
  wire logic start     = state == dms_pkg::DMS_ST_ACCESS;
  wire logic do_write  = start & cmd_wr;
  wire logic gpr_wr    = do_write && eff_area == dms_pkg::DMS_AREA_GPR;
  wire logic ptr_wr    = do_write && eff_area == dms_pkg::DMS_AREA_PTR;
  wire logic ee_wr     = do_write && eff_area == dms_pkg::DMS_AREA_EE;
  wire logic sfr_go    = start && eff_area == dms_pkg::DMS_AREA_SFR;
  wire logic [7:0] gpr_q;

  dms_gpr_ram #(
    .DEPTH  (`DMS_GPR_DEPTH),
    .DATA_W (`DMS_DATA_W)
  ) u_ram (
    .pclk  (pclk),
    .wr_en (gpr_wr),
    .addr  (eff_ofs[6:0]),
    .wdata (cmd_wdata),
    .rdata (gpr_q)
  );

  // Pointer registers read back directly; the indirect ports never store anything.
  logic [7:0] ptr_q;
  always_comb begin
    case (eff_ofs)
      `DMS_PTR_ZERO: ptr_q = sector_zero_pointer;
      `DMS_OFS_ONE:  ptr_q = offset_pointer_one;
      `DMS_SEC_ONE:  ptr_q = sector_pointer_one;
      `DMS_OFS_TWO:  ptr_q = offset_pointer_two;
      `DMS_SEC_TWO:  ptr_q = sector_pointer_two;
      default:       ptr_q = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  wire logic apb_access = psel & penable & ~pready;
  wire logic apb_wr    = psel & penable & pwrite & pready;
  wire logic apb_rd    = psel & penable & ~pwrite;
  wire logic known     = paddr == `DMS_APB_ADDR || paddr == `DMS_APB_WDATA ||
                         paddr == `DMS_APB_CTRL || paddr == `DMS_APB_RDATA ||
                         paddr == `DMS_APB_PTRS || paddr == `DMS_APB_PROT;
  wire logic kick      = apb_wr && paddr == `DMS_APB_CTRL && known;
  wire logic busy      = state != dms_pkg::DMS_ST_IDLE;

  logic [31:0] next_prdata;
  always_comb begin
    case (paddr)
      `DMS_APB_ADDR:  next_prdata = {23'h0, cmd_addr};
      `DMS_APB_WDATA: next_prdata = {24'h0, cmd_wdata};
      `DMS_APB_CTRL:  next_prdata = {29'h0, busy, cmd_ext, cmd_wr};
      `DMS_APB_RDATA: next_prdata = {24'h0, read_data};
      `DMS_APB_PTRS:  next_prdata = {sector_pointer_two, offset_pointer_two,
                                     offset_pointer_one, sector_zero_pointer};
      `DMS_APB_PROT:  next_prdata = {24'h0, protect_mask};
      default:        next_prdata = 32'h0000_0000;
    endcase
  end

  // One wait state: pready is high in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & ~known;
      prdata  <= (apb_rd & ~pready) ? next_prdata : prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_addr     <= 9'h000;
      cmd_wdata    <= 8'h00;
      cmd_wr       <= 1'b0;
      cmd_ext      <= 1'b0;
      protect_mask <= `DMS_PROT_RESET;
    end else if (apb_wr && !busy) begin
      case (paddr)
        `DMS_APB_ADDR:  cmd_addr     <= pwdata[8:0];
        `DMS_APB_WDATA: cmd_wdata    <= pwdata[7:0];
        `DMS_APB_PROT:  protect_mask <= pwdata[7:0];
        `DMS_APB_CTRL: begin
          cmd_wr  <= pwdata[`DMS_CTRL_WR_BIT];
          cmd_ext <= pwdata[`DMS_CTRL_EXT_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dms_pkg::DMS_ST_IDLE;
    end else begin
      case (state)
        dms_pkg::DMS_ST_IDLE:   state <= (kick && !busy) ? dms_pkg::DMS_ST_ACCESS : state;
        dms_pkg::DMS_ST_ACCESS: state <= dms_pkg::DMS_ST_DONE;
        dms_pkg::DMS_ST_DONE:   state <= dms_pkg::DMS_ST_IDLE;
        default:                state <= dms_pkg::DMS_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Pointer and local registers
  // ----------------------------------------------------------------------------
  // Pointer writes are real register writes; the sector only moves through them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sector_zero_pointer <= `DMS_PTR_RESET;
      offset_pointer_one  <= `DMS_PTR_RESET;
      sector_pointer_one  <= `DMS_PTR_RESET;
      offset_pointer_two  <= `DMS_PTR_RESET;
      sector_pointer_two  <= `DMS_PTR_RESET;
      eeprom_control_reg  <= `DMS_EE_CTRL_RESET;
    end else begin
      if (ptr_wr && !is_prot) begin
        case (eff_ofs)
          `DMS_PTR_ZERO: sector_zero_pointer <= cmd_wdata;
          `DMS_OFS_ONE:  offset_pointer_one  <= cmd_wdata;
          `DMS_SEC_ONE:  sector_pointer_one  <= cmd_wdata;
          `DMS_OFS_TWO:  offset_pointer_two  <= cmd_wdata;
          `DMS_SEC_TWO:  sector_pointer_two  <= cmd_wdata;
          default: ;
        endcase
      end
      if (ee_wr) begin
        eeprom_control_reg <= cmd_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read data and external special-function port
  // ----------------------------------------------------------------------------
  // The ports as themselves, unmapped offsets and sector-one RAM all read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data   <= 8'h00;
      gpr_rd_pend <= 1'b0;
      sfr_addr    <= 8'h00;
      sfr_wdata   <= 8'h00;
      sfr_wr      <= 1'b0;
      sfr_rd      <= 1'b0;
    end else begin
      gpr_rd_pend <= start && eff_area == dms_pkg::DMS_AREA_GPR && !cmd_wr;
      sfr_addr    <= sfr_go ? eff_ofs : sfr_addr;
      sfr_wdata   <= sfr_go ? cmd_wdata : sfr_wdata;
      sfr_wr      <= sfr_go & cmd_wr & ~is_prot;
      sfr_rd      <= sfr_go & ~cmd_wr;
      if (start && !cmd_wr) begin
        case (eff_area)
          dms_pkg::DMS_AREA_PTR: read_data <= ptr_q;
          dms_pkg::DMS_AREA_EE:  read_data <= eeprom_control_reg;
          default:               read_data <= 8'h00;
        endcase
      end else if (gpr_rd_pend) begin
        read_data <= gpr_q;
      end else if (sfr_rd) begin
        read_data <= sfr_present ? sfr_rdata : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  ind_zero_sec_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit_ind0 |-> (!eff_sec && eff_ofs == sector_zero_pointer))
    else $error("port zero left sector zero");
  ee_only_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_ofs == `DMS_EE_CTRL && !eff_sec) |-> eff_area == dms_pkg::DMS_AREA_NONE)
    else $error("eeprom control seen in sector zero");
  gpr_sec_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    (eff_sec && eff_ofs[7]) |-> !gpr_wr) else $error("sector one ram written");
  prot_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ptr_wr && is_prot && eff_ofs == `DMS_SEC_TWO) |=> $stable(sector_pointer_two))
    else $error("protected pointer changed");
  ind_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit_ind1 |-> (eff_sec == sector_pointer_one[0] && eff_ofs == offset_pointer_one))
    else $error("pair one redirect wrong");
  ind_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && !cmd_wr && eff_area == dms_pkg::DMS_AREA_IND) |=> read_data == 8'h00)
    else $error("indirect port read nonzero");
  std_sec_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!cmd_ext && !via_ind) |-> !eff_sec) else $error("standard access left sector zero");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("pready held two cycles");

endmodule

// ### dms_sfr_model.sv
// Behavioural model of the special-function registers behind the sector decoder.
`timescale 1ns/10ps

module dms_sfr_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_present
);
  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0] regs [0:127];
  logic [7:0] noise;
  logic       hole;

  // Holes in the map leave the data lines undriven, so a changing pattern is shown.
  assign hole        = (sfr_addr >= 8'h27 && sfr_addr <= 8'h2B) || (sfr_addr >= 8'h4D);
  assign sfr_present = !hole;
  // The model sees no sector, so every register looks the same from both sectors.
  assign sfr_rdata   = hole ? noise : regs[sfr_addr[6:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noise <= 8'h00;
      for (int i = 0; i < 128; i++) begin
        regs[i] <= 8'h00;
      end
    end else begin
      noise <= noise + 8'h5B;
      if (sfr_wr && !hole) begin
        regs[sfr_addr[6:0]] <= sfr_wdata;
      end
    end
  end
endmodule

// ### data_memory_sector_addressing_tb.sv
// Self-checking testbench for the data memory sector decoder.
`timescale 1ns/10ps
`include "dms_map.svh"

module data_memory_sector_addressing_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_rdata;
  logic        sfr_present;
  logic [31:0] q;
  logic        e;
  int          fail_count;
  int          check_count;

  dms_sector_decoder dms_sector_decoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_present(sfr_present));

  dms_sfr_model dms_sfr_model_inst (
    .pclk(pclk), .presetn(presetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_present(sfr_present));

  // --------------------------------------------------------------------------
  // Bus and memory tasks
  // --------------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // A slave that never answers is left to the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        x;
    apb(1'b1, a, d, r, x);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, 32'h00000000, r, x);
  endtask

  task automatic mem(input logic [8:0] a, input logic [7:0] d, input logic w, input logic x,
                     output logic [31:0] r);
    int          n;
    logic [31:0] s;
    n = 0;
    wr(`DMS_APB_ADDR, {23'h000000, a});
    wr(`DMS_APB_WDATA, {24'h000000, d});
    wr(`DMS_APB_CTRL, {30'h00000000, x, w});
    do begin
      rd(`DMS_APB_CTRL, s);
      n++;
    end while (s[2] !== 1'b0 && n < 20);
    if (s[2] !== 1'b0) begin
      fail_count++;
      $display("CHECK FAILED busy expected 0 seen %b", s[2]);
    end
    rd(`DMS_APB_RDATA, r);
  endtask

  task automatic mw(input logic [8:0] a, input logic [7:0] d);
    logic [31:0] r;
    mem(a, d, 1'b1, 1'b1, r);
  endtask

  task automatic mr(input logic [8:0] a, output logic [31:0] r);
    mem(a, 8'h00, 1'b0, 1'b1, r);
  endtask

  // --------------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // --------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // About forty memory accesses need under a thousand cycles; this allows ample margin.
  initial begin
    #(8 * 20000);
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DMS_APB_PTRS, q); check("ptrs reset", q, 32'h00000000);
    rd(`DMS_APB_PROT, q); check("prot reset", q, 32'h00000000);
    mw(9'h080, 8'hA5);
    mw(9'h0FF, 8'h5A);
    mr(9'h080, q); check("gpr low", q, 32'h000000A5);
    mr(9'h0FF, q); check("gpr high", q, 32'h0000005A);
    mw(9'h180, 8'h3C);
    mr(9'h180, q); check("s1 gpr", q, 32'h00000000);
    mr(9'h080, q); check("s0 gpr kept", q, 32'h000000A5);
    mem(9'h181, 8'h66, 1'b1, 1'b0, q);
    mr(9'h081, q); check("plain forces s0", q, 32'h00000066);
    mw(9'h140, 8'h77);
    mr(9'h140, q); check("ee ctrl s1", q, 32'h00000077);
    mr(9'h040, q); check("ee ctrl s0", q, 32'h00000000);
    mw(9'h110, 8'h29);
    mr(9'h010, q); check("sfr mirror", q, 32'h00000029);
    mr(9'h127, q); check("hole 27", q, 32'h00000000);
    mr(9'h07F, q); check("hole 7f", q, 32'h00000000);
    mw(9'h090, 8'h11);
    mw(9'h003, 8'h90);
    mw(9'h004, 8'h01);
    mw(9'h002, 8'hC3);
    mr(9'h090, q); check("pair one s1", q, 32'h00000011);
    mw(9'h004, 8'h00);
    mw(9'h002, 8'hC3);
    mr(9'h090, q); check("pair one s0", q, 32'h000000C3);
    mr(9'h002, q); check("port one read", q, 32'h000000C3);
    mw(9'h00D, 8'h40);
    mw(9'h00E, 8'h01);
    mr(9'h00C, q); check("pair two ee", q, 32'h00000077);
    rd(`DMS_APB_PTRS, q); check("ptrs", q, 32'h01409000);
    mw(9'h001, 8'hA0);
    mw(9'h000, 8'hE1);
    mr(9'h0A0, q); check("port zero", q, 32'h000000E1);
    mw(9'h100, 8'hE2);
    mr(9'h0A0, q); check("port zero s1", q, 32'h000000E2);
    mw(9'h001, 8'h00);
    mr(9'h000, q); check("port as itself", q, 32'h00000000);
    mw(9'h000, 8'h55);
    rd(`DMS_APB_PTRS, q); check("port write void", q, 32'h01409000);
    mw(9'h00A, 8'h11);
    wr(`DMS_APB_PROT, 32'h00000004);
    mw(9'h00A, 8'h22);
    mr(9'h00A, q); check("protected", q, 32'h00000011);
    rd(`DMS_APB_PROT, q); check("prot mask", q, 32'h00000004);
    wr(`DMS_APB_PROT, 32'h00000044);
    mw(9'h00E, 8'h00);
    rd(`DMS_APB_PTRS, q); check("prot pointer", q, 32'h01409000);
    apb(1'b0, 12'h018, 32'h00000000, q, e);
    check("unmapped err", {31'h00000000, e}, 32'h00000001);
    check("unmapped data", q, 32'h00000000);
    end_of_test();
  end
endmodule
